// [inc/pdodt_pkg.sv]
// Shared constants and carriers for the power-down and termination block.
package pdodt_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_TIMING = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // Reset values of the timing counts, in link clock cycles.
  localparam logic [7:0] TCPDED_RST = 8'h01;
  localparam logic [7:0] TXP_RST = 8'h03;
  localparam logic [15:0] TXPDLL_RST = 16'h000A;

  // Reset value of the mode register (termination off, slow exit).
  localparam logic [31:0] MODE_RST = 32'h0000_0000;

  // Termination latency is write latency less this amount.
  localparam logic [4:0] ODTL_SUB = 5'h02;

  // Mode register layout, mirroring the device mode register bits.
  typedef struct packed {
    logic [17:0] rsvd;        // Reads as zero.
    logic [3:0] al;           // Additive latency in cycles.
    logic [3:0] cwl;          // CAS write latency in cycles.
    logic [1:0] rtt_wr;       // Write termination select.
    logic [2:0] rtt_nom;      // Nominal termination select.
    logic dll_pd_fast;        // One keeps the DLL on in precharge power-down.
  } mode_t;

  // Timing register layout.
  typedef struct packed {
    logic [15:0] txpdll;      // Exit wait for DLL commands.
    logic [7:0] txp;          // Exit wait for other commands.
    logic [7:0] tcpded;       // Receiver switch-off delay.
  } timing_t;

  // Pins that arrive from the memory controller.
  typedef struct packed {
    logic ck;                 // Link clock level.
    logic rst_n;              // Device reset, active low.
    logic cke;                // Clock enable.
    logic odt;                // Termination request.
    logic cs_n;               // Chip select, active low.
    logic ras_n;              // Row strobe, active low.
    logic cas_n;              // Column strobe, active low.
    logic we_n;               // Write enable, active low.
  } pins_t;

  // Power-down state machine, one-hot.
  typedef enum logic [4:0] {
    ST_RESET = 5'h01,
    ST_IDLE = 5'h02,
    ST_PD_PEND = 5'h04,
    ST_PD_ACT = 5'h08,
    ST_PD_PRE = 5'h10
  } pd_state_t;

endpackage

// [core/pin_sync.sv]
`timescale 1ns/1ps
// Three-stage synchroniser with a two-stage agreement filter per bit.
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous input and filtered output.
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] s1_r;   // First stage, read only by the second.
  logic [W-1:0] s2_r;   // Second stage.
  logic [W-1:0] s3_r;   // Third stage.
  logic [W-1:0] q_r;    // Filtered value.
  logic [W-1:0] q_nxt;  // Next filtered value.

  // A bit changes only once the second and third stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      assign q_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : q_r[gi];
    end
  endgenerate

  // Register the chain and the filtered value.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule

// [core/odt_delay.sv]
`timescale 1ns/1ps
// Delay line that moves one bit per link clock edge, with a selectable tap.
module odt_delay #(
  parameter int DEPTH = 32,
  parameter int IW = 5
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Step pulse, data in, tap select and delayed output.
  input wire logic i_step,
  input wire logic i_d,
  input wire logic [IW-1:0] i_tap,
  output logic o_q
);

  logic [DEPTH-1:0] sh_r;   // Sample history, newest in bit 0.
  logic [DEPTH-1:0] sh_nxt; // Next history.
  logic q_r;                // Selected tap, registered.
  logic q_nxt;              // Next tap value.

  // Shift on each link edge and pick the tap that matches the latency.
  always_comb begin
    sh_nxt = sh_r;
    if (i_step) begin
      sh_nxt = {sh_r[DEPTH-2:0], i_d};
    end
    q_nxt = sh_r[i_tap];
  end

  // Register the history and the tap.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sh_r <= '0;
      q_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;

endmodule

// [core/pd_odt_ctrl.sv]
// Contract
// R01: Enter power-down on CKE low with NOP.
// R02: Controller keeps CKE high during busy operations.
// R03: Finish row operations before reduced-current power-down.
// R04: Controller resets DLL if unlocked at entry.
// R05: Open bank gives active, else precharge power-down.
// R06: Buffers off; receivers off after tCPDED.
// R07: A12 zero: DLL off, slow exit, tXPDLL.
// R08: DLL on otherwise; fast exit after tXP.
// R09: Controller holds CKE, RESET#, clock, ODT valid.
// R10: RESET# low leaves power-down into reset.
// R11: Controller holds CKE levels at least tCKE.
// R12: Controller limits power-down to nine refresh intervals.
// R13: Exit on CKE high with NOP; wait latency.
// R14: Termination on x16 lines; off in self-refresh.
// R15: Termination only with nonzero mode termination bits.
// R16: ODT pin alone turns termination on/off.
// R17: Synchronous timing while DLL on and locked.
// R18: Controller disables termination in DLL-off mode.
// R19: Termination follows ODT after write latency less two.
// R20: Additive latency also delays internal termination.
// R21: Controller keeps ODT high minimum time.
// R22: Termination off while device drives reads.
// R23: Controller treats minimum ODT high as 4/6.
// R24: Frozen DLL uses undelayed asynchronous termination.
// R25: Controller times exits with configurable counters.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module pd_odt_ctrl
  import pdodt_pkg::*;
#(
  parameter int DLY_DEPTH = 32
) (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_RST,
  // APB slave.
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Memory pins from the controller.
  input wire logic I_CK,
  input wire logic I_RESET_N,
  input wire logic I_CKE,
  input wire logic I_ODT,
  input wire logic I_CS_N,
  input wire logic I_RAS_N,
  input wire logic I_CAS_N,
  input wire logic I_WE_N,
  // Status from the rest of the device core.
  input wire logic I_BANKS_OPEN,
  input wire logic I_OP_BUSY,
  input wire logic I_DLL_LOCKED,
  input wire logic I_SELF_REFRESH,
  input wire logic I_READ_DRIVE,
  // Power-down and termination outputs.
  output logic O_IN_RESET,
  output logic O_PD_ACTIVE,
  output logic O_PD_PRECHARGE,
  output logic O_DLL_ON,
  output logic O_IO_BUF_EN,
  output logic O_CMD_RX_EN,
  output logic O_CMD_READY,
  output logic O_DLL_READY,
  output logic O_RTT_ON,
  output logic [2:0] O_RTT_NOM,
  output logic [1:0] O_RTT_WR
);

  pins_t pin_raw;         // Raw pin bundle.
  pins_t pin;             // Synchronised and filtered pins.
  logic ck_prev_r;        // Link clock level one cycle back.
  logic ck_prev_nxt;      // Next link clock history.
  logic ck_rise;          // One cycle at each link rising edge.
  logic nop_cmd;          // Bus carries NOP or deselect.

  mode_t mode_r;          // Mode register.
  mode_t mode_nxt;        // Next mode register.
  timing_t tim_r;         // Timing register.
  timing_t tim_nxt;       // Next timing register.
  logic [31:0] rdata_r;   // Read data, loaded in the setup phase.
  logic [31:0] rdata_nxt; // Next read data.
  logic [31:0] status;    // Live status word.
  logic acc_hit;          // Address matches a mapped register.

  pd_state_t state_r;     // Power-down state.
  pd_state_t state_nxt;   // Next power-down state.
  logic [7:0] cp_cnt_r;   // Receiver switch-off countdown.
  logic [7:0] cp_cnt_nxt; // Next countdown.
  logic [7:0] xp_cnt_r;   // Exit countdown for plain commands.
  logic [7:0] xp_cnt_nxt; // Next plain countdown.
  logic [15:0] xd_cnt_r;  // Exit countdown for DLL commands.
  logic [15:0] xd_cnt_nxt;// Next DLL countdown.
  logic pd_any;           // Any power-down state.
  logic dll_on;           // DLL running in this state.

  logic [4:0] lat_sum;    // Write latency sum.
  logic [4:0] tap;        // Termination latency tap.
  logic dly_odt;          // ODT delayed by the latency.
  logic rtt_en;           // Mode bits allow termination.
  logic odt_sync;         // Synchronous timing selected.
  logic odt_eff;          // ODT seen by the switch.
  logic rtt_r;            // Termination switch state.
  logic rtt_nxt;          // Next termination state.

  // Bundle the pins so they cross together.
  assign pin_raw = '{ck: I_CK, rst_n: I_RESET_N, cke: I_CKE, odt: I_ODT,
                     cs_n: I_CS_N, ras_n: I_RAS_N, cas_n: I_CAS_N, we_n: I_WE_N};

  // All pins come from outside this clock, so they cross with three flops.
  pin_sync #(
    .W($bits(pins_t))
  ) u_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(pin_raw),
    .o_q(pin)
  );

  // Link clock edge finder and command decode.
  always_comb begin
    ck_prev_nxt = pin.ck;
    ck_rise = pin.ck & ~ck_prev_r;
    nop_cmd = pin.cs_n | (pin.ras_n & pin.cas_n & pin.we_n);
  end

  // Register the link clock history.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ck_prev_r <= 1'b0;
    end else begin
      ck_prev_r <= ck_prev_nxt;
    end
  end

  // The APB answers at once; a read value is captured in the setup phase.
  always_comb begin
    mode_nxt = mode_r;
    tim_nxt = tim_r;
    rdata_nxt = rdata_r;
    acc_hit = (I_PADDR == ADDR_MODE) || (I_PADDR == ADDR_TIMING) || (I_PADDR == ADDR_STATUS);
    if (I_PSEL && !I_PENABLE) begin
      // Setup phase: prepare the read value.
      case (I_PADDR)
        ADDR_MODE: rdata_nxt = mode_r;
        ADDR_TIMING: rdata_nxt = tim_r;
        ADDR_STATUS: rdata_nxt = status;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (I_PSEL && I_PENABLE && I_PWRITE) begin
      // Access phase: the write takes effect; status is read-only.
      if (I_PADDR == ADDR_MODE) begin
        mode_nxt = I_PWDATA;
        mode_nxt.rsvd = '0;
      end else if (I_PADDR == ADDR_TIMING) begin
        tim_nxt = I_PWDATA;
      end
    end
  end

  // Register the software-visible state.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      mode_r <= MODE_RST;
      tim_r <= '{txpdll: TXPDLL_RST, txp: TXP_RST, tcpded: TCPDED_RST};
      rdata_r <= 32'h0000_0000;
    end else begin
      mode_r <= mode_nxt;
      tim_r <= tim_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Bus answer: no wait states, error for an unmapped address.
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~acc_hit;
  assign O_PRDATA = rdata_r;

  // Status word: state, DLL, termination, receivers and exit readiness.
  assign status = {22'h00_0000, O_DLL_READY, O_CMD_READY, O_CMD_RX_EN, rtt_r, dll_on, state_r};

  // Power-down state machine; CKE entry and exit are sampled at link clock rising edges.
  always_comb begin
    state_nxt = state_r;
    cp_cnt_nxt = cp_cnt_r;
    xp_cnt_nxt = xp_cnt_r;
    xd_cnt_nxt = xd_cnt_r;
    // Exit countdowns run on every link edge until they reach zero.
    if (ck_rise && xp_cnt_r != 8'h00) begin
      xp_cnt_nxt = xp_cnt_r - 8'h01; // R13
    end
    if (ck_rise && xd_cnt_r != 16'h0000) begin
      xd_cnt_nxt = xd_cnt_r - 16'h0001; // R07
    end
    // The receiver countdown runs while powered down.
    if (ck_rise && pd_any && cp_cnt_r != 8'h00) begin
      cp_cnt_nxt = cp_cnt_r - 8'h01; // R06
    end
    if (!pin.rst_n) begin
      // Reset pin low wins over every state, powered down or not.
      state_nxt = ST_RESET; // R10
      xp_cnt_nxt = 8'h00;
      xd_cnt_nxt = 16'h0000;
    end else begin
      case (state_r)
        ST_RESET: begin
          // Reset released: back to normal operation.
          state_nxt = ST_IDLE;
        end
        ST_IDLE: begin
          // Entry when CKE is sampled low with NOP or deselect.
          if (ck_rise && !pin.cke && nop_cmd) begin
            state_nxt = ST_PD_PEND; // R01
            cp_cnt_nxt = tim_r.tcpded; // R06
          end
        end
        ST_PD_PEND: begin
          // Row operations in flight finish before the low-current state.
          if (ck_rise && pin.cke && nop_cmd) begin
            state_nxt = ST_IDLE; // R13
            xp_cnt_nxt = tim_r.txp;
            xd_cnt_nxt = {8'h00, tim_r.txp};
          end else if (!I_OP_BUSY) begin
            // Any open bank decides active against precharge.
            state_nxt = I_BANKS_OPEN ? ST_PD_ACT : ST_PD_PRE; // R03 R05
          end
        end
        ST_PD_ACT: begin
          // Fast exit: the DLL stayed on.
          if (ck_rise && pin.cke && nop_cmd) begin
            state_nxt = ST_IDLE; // R13
            xp_cnt_nxt = tim_r.txp; // R08
            xd_cnt_nxt = {8'h00, tim_r.txp};
          end
        end
        ST_PD_PRE: begin
          // Slow exit when the DLL was frozen, fast otherwise.
          if (ck_rise && pin.cke && nop_cmd) begin
            state_nxt = ST_IDLE; // R13
            xp_cnt_nxt = tim_r.txp;
            xd_cnt_nxt = mode_r.dll_pd_fast ? {8'h00, tim_r.txp} : tim_r.txpdll; // R07 R08
          end
        end
        default: begin
          state_nxt = ST_RESET;
        end
      endcase
    end
  end

  // Register the state machine and its counters.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      state_r <= ST_RESET;
      cp_cnt_r <= 8'h00;
      xp_cnt_r <= 8'h00;
      xd_cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cp_cnt_r <= cp_cnt_nxt;
      xp_cnt_r <= xp_cnt_nxt;
      xd_cnt_r <= xd_cnt_nxt;
    end
  end

  // DLL is off in reset and frozen in precharge power-down with the slow-exit setting.
  always_comb begin
    pd_any = (state_r == ST_PD_PEND) || (state_r == ST_PD_ACT) || (state_r == ST_PD_PRE);
    dll_on = !((state_r == ST_PD_PRE) && !mode_r.dll_pd_fast) && (state_r != ST_RESET); // R07 R08
  end

  // Termination latency is write latency plus additive latency less two.
  always_comb begin
    lat_sum = {1'b0, mode_r.cwl} + {1'b0, mode_r.al}; // R20
    tap = (lat_sum >= ODTL_SUB) ? (lat_sum - ODTL_SUB) : 5'h00; // R19
  end

  // ODT history, one step per link rising edge.
  odt_delay #(
    .DEPTH(DLY_DEPTH),
    .IW(5)
  ) u_odt_dly (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_step(ck_rise),
    .i_d(pin.odt),
    .i_tap(tap),
    .o_q(dly_odt)
  );

  // Termination switch: pin only, gated by mode, self-refresh and reads.
  always_comb begin
    rtt_en = (mode_r.rtt_nom != 3'h0) || (mode_r.rtt_wr != 2'h0); // R15
    odt_sync = dll_on && I_DLL_LOCKED; // R17
    // A frozen DLL bypasses the latency line.
    odt_eff = odt_sync ? dly_odt : pin.odt; // R24
    rtt_nxt = rtt_en && odt_eff; // R16
    if (I_SELF_REFRESH || state_r == ST_RESET) begin
      rtt_nxt = 1'b0; // R14
    end
    if (I_READ_DRIVE) begin
      // Termination returns as soon as the device stops driving.
      rtt_nxt = 1'b0; // R22
    end
  end

  // Register the termination switch.
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      rtt_r <= 1'b0;
    end else begin
      rtt_r <= rtt_nxt;
    end
  end

  // Outputs drawn from the state machine, counters and registers.
  assign O_IN_RESET = (state_r == ST_RESET);
  assign O_PD_ACTIVE = (state_r == ST_PD_ACT);
  assign O_PD_PRECHARGE = (state_r == ST_PD_PRE);
  assign O_DLL_ON = dll_on;
  assign O_IO_BUF_EN = ~pd_any; // R06
  assign O_CMD_RX_EN = ~(pd_any && cp_cnt_r == 8'h00); // R06
  assign O_CMD_READY = (xp_cnt_r == 8'h00);
  assign O_DLL_READY = (xd_cnt_r == 16'h0000);
  // The same switch serves all upper and lower data, strobe and mask lines.
  assign O_RTT_ON = rtt_r; // R14
  assign O_RTT_NOM = mode_r.rtt_nom;
  assign O_RTT_WR = mode_r.rtt_wr;

endmodule

// [tb/pd_odt_ctrl_chk.sv]
`timescale 1ns/1ps
// Port-level checker for power-down and termination behaviour.
module pd_odt_ctrl_chk (
  // Clock, reset and watched inputs.
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_RESET_N,
  input wire logic I_SELF_REFRESH,
  input wire logic I_READ_DRIVE,
  // Watched outputs.
  input wire logic O_IN_RESET,
  input wire logic O_PD_ACTIVE,
  input wire logic O_PD_PRECHARGE,
  input wire logic O_DLL_ON,
  input wire logic O_IO_BUF_EN,
  input wire logic O_CMD_RX_EN,
  input wire logic O_CMD_READY,
  input wire logic O_DLL_READY,
  input wire logic O_RTT_ON,
  input wire logic [2:0] O_RTT_NOM,
  input wire logic [1:0] O_RTT_WR
);
  // All checks run on the system clock.
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  // A power-down state is left for idle, not for reset.
  sequence pd_exit;
    $fell(O_PD_ACTIVE || O_PD_PRECHARGE) ##0 !O_IN_RESET;
  endsequence
  // Both termination select fields read zero.
  sequence rtt_off_fields;
    (O_RTT_NOM == 3'h0 && O_RTT_WR == 2'h0) [*2];
  endsequence
  chk_pd_buf_off: assert property ((O_PD_ACTIVE || O_PD_PRECHARGE) |-> !O_IO_BUF_EN)
    else $error("buffers on in power-down");
  chk_rx_late_off: assert property ($fell(O_IO_BUF_EN) |-> O_CMD_RX_EN [*2])
    else $error("receivers off too early");
  chk_one_pd_mode: assert property (!(O_PD_ACTIVE && O_PD_PRECHARGE))
    else $error("two power-down modes at once");
  chk_act_dll_on: assert property (O_PD_ACTIVE |-> O_DLL_ON)
    else $error("dll off in active power-down");
  chk_exit_wait: assert property (pd_exit |-> !O_CMD_READY ##[1:1000] O_CMD_READY)
    else $error("exit latency wrong");
  chk_exit_dll: assert property (pd_exit |-> !O_DLL_READY ##[1:1000] O_DLL_READY)
    else $error("dll exit latency wrong");
  chk_pin_reset: assert property ($fell(I_RESET_N) |-> ##[1:12] O_IN_RESET)
    else $error("reset pin not obeyed");
  chk_reset_quiet: assert property (O_IN_RESET [*2] |-> !O_RTT_ON && !O_DLL_ON)
    else $error("active outputs in reset");
  chk_sr_rtt_off: assert property (I_SELF_REFRESH [*2] |-> !O_RTT_ON)
    else $error("termination in self-refresh");
  chk_read_rtt_off: assert property (I_READ_DRIVE [*2] |-> !O_RTT_ON)
    else $error("termination while driving");
  chk_fields_rtt_off: assert property (rtt_off_fields |-> !O_RTT_ON)
    else $error("termination while disabled");
endmodule
bind pd_odt_ctrl pd_odt_ctrl_chk pd_odt_ctrl_chk_i (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_RESET_N(I_RESET_N),
  .I_SELF_REFRESH(I_SELF_REFRESH), .I_READ_DRIVE(I_READ_DRIVE), .O_IN_RESET(O_IN_RESET),
  .O_PD_ACTIVE(O_PD_ACTIVE), .O_PD_PRECHARGE(O_PD_PRECHARGE), .O_DLL_ON(O_DLL_ON), .O_IO_BUF_EN(O_IO_BUF_EN),
  .O_CMD_RX_EN(O_CMD_RX_EN), .O_CMD_READY(O_CMD_READY), .O_DLL_READY(O_DLL_READY), .O_RTT_ON(O_RTT_ON),
  .O_RTT_NOM(O_RTT_NOM), .O_RTT_WR(O_RTT_WR));

// [tb/mem_ctl_model.sv]
`timescale 1ns/1ps
// Behavioural memory controller on the far side of the pins.
module mem_ctl_model
  import pdodt_pkg::*;
(
  // Pins toward the device.
  output pins_t o_pins
);
  // Pin levels; the reset pin starts asserted.
  pins_t p = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  assign o_pins = p;
  // The link clock runs free and stable, power-down included.
  always #80 p.ck = ~p.ck;
  // Lets n rises pass, then stops at a falling edge.
  task automatic rises(input int n);
    repeat (n) @(posedge p.ck);
    @(negedge p.ck);
  endtask
  // Moves clock enable with a deselect and holds it; never during bursts.
  task automatic set_cke(input logic v, input int hold);
    @(negedge p.ck);
    p.cke = v;
    p.cs_n = 1'b1;
    p.ras_n = 1'b1;
    rises(hold);
  endtask
  // Clock enable low together with a row command, which must be refused.
  task automatic refused_entry;
    @(negedge p.ck);
    p.cke = 1'b0;
    p.cs_n = 1'b0;
    p.ras_n = 1'b0;
    rises(3);
  endtask
  // Termination request; a zero hold changes it at once.
  task automatic set_odt(input logic v, input int hold);
    if (hold > 0) @(negedge p.ck);
    p.odt = v;
    if (hold > 0) rises(hold);
  endtask
  // Device reset pin.
  task automatic set_rst(input logic v, input int hold);
    @(negedge p.ck);
    p.rst_n = v;
    rises(hold);
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
// Self-checking bench: registers over APB, power-down and termination.
module tb;
  import pdodt_pkg::*;
  logic clk = 1'b0; // System clock.
  logic rst = 1'b1; // Block reset.
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, v;
  logic pready, pslverr, e;
  logic banks = 1'b0, busy = 1'b0, lock = 1'b0, sr = 1'b0, rdrv = 1'b0; // Core status.
  logic in_rst, pd_act, pd_pre, dll_on, io_en, rx_en, cmd_rdy, dll_rdy, rtt_on;
  logic [2:0] rtt_nom;
  logic [1:0] rtt_wr;
  pins_t pins;
  int bad_count = 0, total_checks = 0, ck_rises = 0;
  always #5 clk = ~clk;
  always @(posedge pins.ck) ck_rises++;
  mem_ctl_model mem_ctl_model_i (.o_pins(pins));
  pd_odt_ctrl #(.DLY_DEPTH(32)) pd_odt_ctrl_i (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_CK(pins.ck), .I_RESET_N(pins.rst_n), .I_CKE(pins.cke), .I_ODT(pins.odt),
    .I_CS_N(pins.cs_n), .I_RAS_N(pins.ras_n), .I_CAS_N(pins.cas_n), .I_WE_N(pins.we_n), .I_BANKS_OPEN(banks),
    .I_OP_BUSY(busy), .I_DLL_LOCKED(lock), .I_SELF_REFRESH(sr), .I_READ_DRIVE(rdrv), .O_IN_RESET(in_rst),
    .O_PD_ACTIVE(pd_act), .O_PD_PRECHARGE(pd_pre), .O_DLL_ON(dll_on), .O_IO_BUF_EN(io_en),
    .O_CMD_RX_EN(rx_en), .O_CMD_READY(cmd_rdy), .O_DLL_READY(dll_rdy), .O_RTT_ON(rtt_on),
    .O_RTT_NOM(rtt_nom), .O_RTT_WR(rtt_wr));
  // Compares one value and counts it.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; read data and error land in v and e.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Any wait states are sat out; only the watchdog ends a hung access.
    while (pready !== 1'b1) @(posedge clk);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads status until the masked bits match, bounded.
  task automatic poll(input logic [31:0] m, input logic [31:0] x);
    int k;
    for (k = 0; k == 0 || (k < 300 && (v & m) !== x); k++) apb(1'b0, ADDR_STATUS, 32'h0);
    check("status", v & m, x);
  endtask
  // Counts link clock rises from an ODT change to the termination change.
  task automatic odt_lat(input logic lvl, input int exp);
    int s, k;
    @(negedge pins.ck);
    s = ck_rises;
    mem_ctl_model_i.set_odt(lvl, 0);
    for (k = 0; k < 400 && rtt_on !== lvl; k++) @(posedge clk);
    check("rtt latency", ck_rises - s, exp);
    mem_ctl_model_i.rises(4);
  endtask
  // Prints the verdict and stops.
  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Cuts a hang short; the tests need well under a fifth of this span.
  initial begin
    #500us;
    bad_count++;
    complete_run;
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    lock <= 1'b1;
    apb(1'b0, ADDR_MODE, 32'h0);
    check("mode", v, MODE_RST);
    apb(1'b0, ADDR_TIMING, 32'h0);
    check("timing", v, {TXPDLL_RST, TXP_RST, TCPDED_RST});
    poll(32'h3FF, 32'h381);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    check("unmapped err", e, 1);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped data", {v[31:1], e}, 1);
    mem_ctl_model_i.set_rst(1'b1, 4);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_TIMING, 32'h0005_0202);
    apb(1'b0, ADDR_TIMING, 32'h0);
    check("timing", v, 32'h0005_0202);
    poll(32'h3FF, 32'h3A2);
    mem_ctl_model_i.refused_entry();
    poll(32'h1F, 32'h2);
    mem_ctl_model_i.set_cke(1'b1, 4);
    @(posedge clk);
    busy <= 1'b1;
    banks <= 1'b1;
    mem_ctl_model_i.set_cke(1'b0, 4);
    poll(32'h1F, 32'h4);
    check("io buffers", io_en, 0);
    mem_ctl_model_i.set_cke(1'b1, 4);
    poll(32'h1F, 32'h2);
    mem_ctl_model_i.set_cke(1'b0, 4);
    poll(32'h1F, 32'h4);
    @(posedge clk);
    busy <= 1'b0;
    poll(32'h3F, 32'h28);
    poll(32'h80, 32'h0);
    mem_ctl_model_i.set_cke(1'b1, 4);
    poll(32'h1F, 32'h2);
    poll(32'h300, 32'h300);
    @(posedge clk);
    banks <= 1'b0;
    mem_ctl_model_i.set_cke(1'b0, 4);
    poll(32'h3F, 32'h10);
    mem_ctl_model_i.set_cke(1'b1, 2);
    poll(32'h100, 32'h100);
    check("dll ready", dll_rdy, 0);
    poll(32'h200, 32'h200);
    apb(1'b1, ADDR_MODE, 32'h1);
    mem_ctl_model_i.set_cke(1'b0, 4);
    poll(32'h3F, 32'h30);
    mem_ctl_model_i.set_rst(1'b0, 4);
    poll(32'h1F, 32'h1);
    mem_ctl_model_i.set_cke(1'b1, 2);
    mem_ctl_model_i.set_rst(1'b1, 4);
    poll(32'h1F, 32'h2);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_MODE, (i == 0) ? 32'h0000_0142 : 32'h0000_0950);
      // The mode register settles at the access edge, so look half a cycle later.
      @(negedge clk);
      check("rtt fields", {rtt_nom, rtt_wr}, (i == 0) ? 5'h04 : 5'h01);
      odt_lat(1'b1, 4 + 2 * i);
      odt_lat(1'b0, 4 + 2 * i);
    end
    apb(1'b1, ADDR_MODE, 32'h0000_0142);
    mem_ctl_model_i.set_cke(1'b0, 4);
    poll(32'h3F, 32'h10);
    odt_lat(1'b1, 0);
    odt_lat(1'b0, 0);
    mem_ctl_model_i.set_cke(1'b1, 4);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      sr <= (k == 0);
      rdrv <= (k == 1);
      if (k == 2) apb(1'b1, ADDR_MODE, 32'h0000_0140);
      mem_ctl_model_i.set_odt(1'b1, 10);
      check("rtt forced", rtt_on, 0);
      mem_ctl_model_i.set_odt(1'b0, 10);
    end
    complete_run;
  end
endmodule
